// *** mbr_pkg.sv ***
package mbr_pkg;

    // ****************************************************************
    // Register map and reset values.
    // ****************************************************************
    localparam logic [15:0] MBR_ADDR_CONTROL_0 = 16'hff4c;
    localparam logic [15:0] MBR_ADDR_CONTROL_1 = 16'hff4d;
    localparam logic [15:0] MBR_ADDR_BAUD_RATE_CONTROL = 16'hff4e;
    localparam logic [7:0] MBR_RST_CONTROL_0 = 8'h10;
    localparam logic [2:0] MBR_RST_CONTROL_1 = 3'h0;
    localparam logic [4:0] MBR_RST_BAUD_RATE_CONTROL = 5'h1f;

    // ****************************************************************
    // Field positions and masks.
    // ****************************************************************
    localparam int MBR_ENABLE_BIT = 7;
    localparam logic [7:0] MBR_CONTROL_0_MASK = 8'h93;
    localparam int MBR_SELECT_MSB = 2;
    localparam int MBR_DIVISOR_MSB = 4;
    localparam logic [4:0] MBR_DIVISOR_MIN = 5'h04;
    localparam logic [2:0] MBR_SELECT_LAST_LEGAL = 3'h5;

    // ****************************************************************
    // Carriers.
    // ****************************************************************
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } mbr_access_t;

    typedef struct packed {
        logic [4:0] pre_cnt;
        logic [4:0] div_cnt;
        logic [7:0] control_0;
        logic [2:0] base_select;
        logic [4:0] divisor;
        logic div_pulse;
        logic baud;
        logic [7:0] rd_data;
    } mbr_state_t;

endpackage

// *** mbr_divider.sv ***
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Reset loads the baud rate register with 1fh, divisor 31.
// - Divisor sits in bits 4 to 0; bits 7 to 5 read zero.
// - Divisor equals field value; codes with upper bits 000 act as four.
// - Counter on the base clock ticks gives one output per k ticks.
// - Bit clock is the counter output halved, base over two k.
// - Base clock is chosen by the three select bits of register one.
// - Select codes 0 to 5 give divide by 1 to 32; 6, 7 prohibited.
// - With enable low the generator is stopped.
module mbr_divider
    import mbr_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [15:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rd_data_out,
    output logic enable_out,
    output logic counter_pulse_out,
    output logic baud_clk_out
);

    // ****************************************************************
    // State and combinational helpers.
    // ****************************************************************
    mbr_access_t acc;
    mbr_state_t s_q;
    mbr_state_t s_d;
    logic enable;
    logic [4:0] k_eff;
    logic [4:0] pre_mask;
    logic base_tick;

    assign acc = '{addr: addr_in, wr: wr_in, rd: rd_in, wdata: wdata_in};
    assign enable = s_q.control_0[MBR_ENABLE_BIT];

    always_comb
    begin
        // Upper bits all zero fold onto the smallest divisor.
        k_eff = (s_q.divisor[4:2] == 3'h0) ? MBR_DIVISOR_MIN : s_q.divisor;
        // Prescaler tap for the selected power of two.
        case (s_q.base_select)
            3'h0: pre_mask = 5'h00;
            3'h1: pre_mask = 5'h01;
            3'h2: pre_mask = 5'h03;
            3'h3: pre_mask = 5'h07;
            3'h4: pre_mask = 5'h0f;
            3'h5: pre_mask = 5'h1f;
            default: pre_mask = 5'h00;
        endcase
        base_tick = enable && (s_q.base_select <= MBR_SELECT_LAST_LEGAL)
            && ((s_q.pre_cnt & pre_mask) == pre_mask);
    end

    // ****************************************************************
    // Next state.
    // ****************************************************************
    always_comb
    begin
        s_d = s_q;
        s_d.div_pulse = 1'b0;
        if (acc.wr)
        begin
            // Registers keep only their defined bits of each written byte.
            case (acc.addr)
                MBR_ADDR_CONTROL_0: s_d.control_0 = acc.wdata & MBR_CONTROL_0_MASK;
                MBR_ADDR_CONTROL_1: s_d.base_select = acc.wdata[MBR_SELECT_MSB:0];
                MBR_ADDR_BAUD_RATE_CONTROL: s_d.divisor = acc.wdata[MBR_DIVISOR_MSB:0];
                default: s_d.control_0 = s_q.control_0;
            endcase
        end
        if (acc.rd)
        begin
            case (acc.addr)
                MBR_ADDR_CONTROL_0: s_d.rd_data = s_q.control_0;
                MBR_ADDR_CONTROL_1: s_d.rd_data = {5'h00, s_q.base_select};
                MBR_ADDR_BAUD_RATE_CONTROL: s_d.rd_data = {3'h0, s_q.divisor};
                default: s_d.rd_data = 8'h00;
            endcase
        end
        if (!enable)
        begin
            // Stopped generator rests in its start state.
            s_d.pre_cnt = 5'h00;
            s_d.div_cnt = 5'h00;
            s_d.baud = 1'b0;
        end
        else
        begin
            s_d.pre_cnt = s_q.pre_cnt + 5'h01;
            if (base_tick)
            begin
                if (s_q.div_cnt == k_eff - 5'h01)
                begin
                    s_d.div_cnt = 5'h00;
                    s_d.div_pulse = 1'b1;
                    s_d.baud = ~s_q.baud;
                end
                else
                begin
                    s_d.div_cnt = s_q.div_cnt + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s_q <= '{pre_cnt: 5'h00, div_cnt: 5'h00, control_0: MBR_RST_CONTROL_0,
                base_select: MBR_RST_CONTROL_1, divisor: MBR_RST_BAUD_RATE_CONTROL,
                div_pulse: 1'b0, baud: 1'b0, rd_data: 8'h00};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    assign rd_data_out = s_q.rd_data;
    assign enable_out = s_q.control_0[MBR_ENABLE_BIT];
    assign counter_pulse_out = s_q.div_pulse;
    assign baud_clk_out = s_q.baud;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    logic seen_q;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            seen_q <= 1'b0;
        end
        else
        begin
            seen_q <= 1'b1;
        end
    end

    a_reset_divisor: assert property (@(posedge clk_in) disable iff (rst_in)
        !seen_q |-> (s_q.divisor == 5'h1f && k_eff == 5'd31))
        else $error("Divisor not 31 after reset.");


    a_upper_bits_zero: assert property (@(posedge clk_in) disable iff (rst_in)
        (rd_in && addr_in == MBR_ADDR_BAUD_RATE_CONTROL) |=> (rd_data_out[7:5] == 3'h0
            && rd_data_out[4:0] == $past(s_q.divisor)))
        else $error("Baud rate register read back wrong.");


    a_divisor_floor: assert property (@(posedge clk_in) disable iff (rst_in)
        (s_q.divisor[4:2] == 3'h0) |-> (k_eff == 5'd4))
        else $error("Small divisor code not folded to four.");


    a_counter_wrap: assert property (@(posedge clk_in) disable iff (rst_in)
        counter_pulse_out |-> ($past(s_q.div_cnt) == $past(k_eff) - 5'h01
            && s_q.div_cnt == 5'h00))
        else $error("Counter output not at k count.");


    a_baud_half: assert property (@(posedge clk_in) disable iff (rst_in)
        $changed(baud_clk_out) && enable_out |-> counter_pulse_out)
        else $error("Bit clock changed without counter output.");


    a_full_rate_tick: assert property (@(posedge clk_in) disable iff (rst_in)
        (enable && s_q.base_select == 3'h0 && s_q.divisor == 5'h04 && s_q.div_cnt == 5'h00
            && !wr_in) ##1 !wr_in |=> ##1 (s_q.div_cnt == 5'h03))
        else $error("Undivided base clock not counted every cycle.");


    a_prohibited_idle: assert property (@(posedge clk_in) disable iff (rst_in)
        (s_q.base_select > 3'h5) |-> !base_tick)
        else $error("Prohibited select produced a tick.");


    a_stopped_rest: assert property (@(posedge clk_in) disable iff (rst_in)
        !enable_out |=> (!counter_pulse_out && !baud_clk_out && s_q.div_cnt == 5'h00))
        else $error("Generator ran while disabled.");

    a_prescaler_rest: assert property (@(posedge clk_in) disable iff (rst_in)
        !enable_out |=> (s_q.pre_cnt == 5'h00))
        else $error("Prescaler ran while disabled.");

    a_bit_clock_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        (enable_out && !counter_pulse_out) |-> (baud_clk_out == $past(baud_clk_out)))
        else $error("Bit clock moved between counter outputs.");


    a_restart_state: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(enable_out) |-> (s_q.div_cnt == 5'h00 && s_q.pre_cnt == 5'h00 && !baud_clk_out))
        else $error("Generator did not start from rest.");

    // ****************************************************************
    // Scenarios reached.
    // ****************************************************************
    c_baud_toggle: cover property (@(posedge clk_in) disable iff (rst_in)
        $rose(baud_clk_out));
    c_slowest: cover property (@(posedge clk_in) disable iff (rst_in)
        counter_pulse_out && s_q.base_select == 3'h5 && k_eff == 5'd31);
    c_disable_run: cover property (@(posedge clk_in) disable iff (rst_in)
        $fell(enable_out) && s_q.div_cnt != 5'h00);
    c_fastest: cover property (@(posedge clk_in) disable iff (rst_in)
        counter_pulse_out && s_q.base_select == 3'h0 && k_eff == 5'd4);
    c_prohibited_run: cover property (@(posedge clk_in) disable iff (rst_in)
        enable_out && s_q.base_select > MBR_SELECT_LAST_LEGAL);

endmodule
`default_nettype wire

// *** mbr_divider_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module mbr_divider_tb_top;
    import mbr_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [15:0] addr_in = 16'h0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] wdata_in = 8'h0;
    logic [7:0] rd_data_out;
    logic enable_out;
    logic counter_pulse_out;
    logic baud_clk_out;
    int failures = 0;
    int total_checks = 0;
    int npulse = 0;
    int cnt = 0;
    logic rd_chk = 1'b0;
    logic have_prev = 1'b0;
    logic baud_prev = 1'b0;
    logic [7:0] rd_q[$];
    int per_q[$];
    always #5 clk_in = ~clk_in;
    mbr_divider mbr_divider_i (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in), .rd_data_out(rd_data_out),
        .enable_out(enable_out), .counter_pulse_out(counter_pulse_out),
        .baud_clk_out(baud_clk_out));
    // ****************************************************************
    // Bus tasks and verdict.
    // ****************************************************************
    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
    endtask
    task automatic run_rate(input logic [2:0] n, input logic [4:0] code);
        int k;
        int i;
        k = (code < MBR_DIVISOR_MIN) ? 4 : int'(code);
        wr_reg(MBR_ADDR_CONTROL_0, 8'h00);
        wr_reg(MBR_ADDR_CONTROL_1, {5'h0, n});
        wr_reg(MBR_ADDR_BAUD_RATE_CONTROL, {3'h0, code});
        wr_reg(MBR_ADDR_CONTROL_0, 8'h80);
        repeat (2) per_q.push_back(k << n);
        i = 0;
        while (per_q.size() > 0 && i < 8000)
        begin
            @(posedge clk_in);
            i++;
        end
        if (per_q.size() > 0)
        begin
            failures++;
            $display("Error at %0t: no bit clock", $time);
            print_verdict();
        end
        wr_reg(MBR_ADDR_CONTROL_0, 8'h00);
    endtask
    // ****************************************************************
    // Output monitor.
    // ****************************************************************
    always @(posedge clk_in)
    begin
        logic [7:0] e;
        int p;
        if (rd_chk)
        begin
            e = rd_q.pop_front();
            `CHK(rd_data_out, e)
        end
        rd_chk = rd_in;
        cnt++;
        if (counter_pulse_out === 1'b1)
        begin
            npulse++;
            `CHK(baud_clk_out, ~baud_prev)
            if (have_prev && per_q.size() > 0)
            begin
                p = per_q.pop_front();
                `CHK(cnt, p)
            end
            cnt = 0;
            have_prev = 1'b1;
        end
        if (enable_out !== 1'b1)
            have_prev = 1'b0;
        baud_prev = baud_clk_out;
    end
    initial
    begin
        logic [7:0] d;
        int p;
        int i;
        void'($urandom(62));
        repeat (4) @(posedge clk_in);
        `CHK(enable_out, 1'b0)
        rst_in <= 1'b0;
        rd_reg(MBR_ADDR_CONTROL_0, 8'h10);
        rd_reg(MBR_ADDR_CONTROL_1, 8'h00);
        rd_reg(MBR_ADDR_BAUD_RATE_CONTROL, 8'h1f);
        $display("test reset values done");
        for (i = 0; i < 8; i++)
        begin
            d = 8'($urandom());
            wr_reg(MBR_ADDR_BAUD_RATE_CONTROL, d);
            rd_reg(MBR_ADDR_BAUD_RATE_CONTROL, {3'h0, d[4:0]});
            wr_reg(MBR_ADDR_CONTROL_1, d);
            rd_reg(MBR_ADDR_CONTROL_1, {5'h0, d[2:0]});
            rd_reg(16'hff4f, 8'h00);
        end
        $display("test register access done");
        for (i = 0; i < 6; i++)
            run_rate(3'(i), 5'(4 + $urandom_range(27)));
        run_rate(3'h0, 5'h02);
        run_rate(3'h1, 5'h1f);
        run_rate(3'h0, 5'h00);
        $display("test rates done");
        repeat (4) @(posedge clk_in);
        p = npulse;
        repeat (100) @(posedge clk_in);
        `CHK(npulse, p)
        `CHK(baud_clk_out, 1'b0)
        wr_reg(MBR_ADDR_CONTROL_1, 8'h06);
        wr_reg(MBR_ADDR_CONTROL_0, 8'h80);
        p = npulse;
        repeat (300) @(posedge clk_in);
        `CHK(npulse, p)
        $display("test stop and prohibited done");
        wr_reg(MBR_ADDR_CONTROL_0, 8'h00);
        wr_reg(MBR_ADDR_CONTROL_1, 8'h00);
        wr_reg(MBR_ADDR_BAUD_RATE_CONTROL, 8'h04);
        wr_reg(MBR_ADDR_CONTROL_0, 8'h80);
        i = 0;
        do
        begin
            @(posedge clk_in);
            #1;
            i++;
        end
        while (counter_pulse_out !== 1'b1 && i < 50);
        `CHK(i, 4)
        $display("test restart done");
        print_verdict();
    end
endmodule
`default_nettype wire
